// ---- common/rfac_pkg.sv ----
// Shared constants and carrier types for the register field access cells
package rfac_pkg;

	// Host port geometry
	localparam int RFAC_ADDR_W   = 4;
	localparam int RFAC_DATA_W   = 16;
	localparam int RFAC_REG_CNT  = 4;
	localparam int RFAC_ATTR_W   = 4;

	// Field attribute codes, one per bit cell
	typedef enum logic [RFAC_ATTR_W-1:0] {
		RFAC_RESERVED         = 4'h0,
		RFAC_READ_ONLY        = 4'h1,
		RFAC_WRITE_ONLY       = 4'h2,
		RFAC_READ_WRITE       = 4'h3,
		RFAC_WRITE_ONE_CLEAR  = 4'h4,
		RFAC_WRITE_ANY_CLEAR  = 4'h5,
		RFAC_CLEAR_ON_READ    = 4'h6,
		RFAC_LATCH_LOW        = 4'h7,
		RFAC_LATCH_HIGH       = 4'h8,
		RFAC_SELF_CLEARING    = 4'h9,
		RFAC_SELF_SETTING     = 4'hA,
		RFAC_RO_LATCHED_HIGH  = 4'hB
	} rfac_attr_t;

	localparam logic [RFAC_ATTR_W-1:0] RFAC_ATTR_LAST = 4'hB;

	// Reset values of the answer path
	localparam logic [RFAC_DATA_W-1:0] RFAC_DATA_RST = 16'h0000;
	localparam logic [RFAC_DATA_W-1:0] RFAC_UNREAD   = 16'h0000;

	// Host request: one access per cycle, write wins if both strobes are high
	typedef struct packed {
		logic                   rd;
		logic                   wr;
		logic [RFAC_ADDR_W-1:0] addr;
		logic [RFAC_DATA_W-1:0] wdata;
	} rfac_req_t;

	// Answer to the host, one cycle after the request
	typedef struct packed {
		logic                   valid;
		logic                   err;
		logic [RFAC_DATA_W-1:0] rdata;
	} rfac_rsp_t;

	localparam rfac_rsp_t RFAC_RSP_RST = '{valid: 1'b0, err: 1'b0, rdata: RFAC_DATA_RST};

endpackage : rfac_pkg

// ---- rtl/rfac_bank.sv ----
// Bank of register words built from per-bit attribute cells
// What this block does
// - read-only bits return their value and ignore every write.
// - write-only bits accept writes; they always read back as zero.
// - write-one-to-clear bits clear where a one is written, keep where zero.
// - write-any-clear bits clear on any write, whatever the data.
// - clear-on-read bits return contents, then clear; writes do nothing.
// - latch-low bits hold a captured low until their register is read.
// - self-clearing bits return to zero alone; zero writes ignored; readable.
// - self-setting bits return to one alone; one writes ignored; readable.
// - read-only latched-high bits stay high after the condition until read.
// - after that read, the bit follows whether the condition persists.
// - soft-reset-immune bits keep their value on a software reset.
// - read-write bits store the written value and return it on reads.
// - readable write-any-clear bits report value and clear on any write.
`timescale 1ns/1ps
module rfac_bank
	import rfac_pkg::*;
#(
	parameter int                                   REG_CNT = RFAC_REG_CNT,
	parameter logic [REG_CNT*RFAC_DATA_W*RFAC_ATTR_W-1:0] ATTR_MAP =
		{(REG_CNT*RFAC_DATA_W){RFAC_READ_WRITE}},
	parameter logic [REG_CNT*RFAC_DATA_W-1:0]       RESET_MAP  = '0,
	parameter logic [REG_CNT*RFAC_DATA_W-1:0]       IMMUNE_MAP = '0
)
(
	// Clock and reset
	input  wire logic                           clk,
	input  wire logic                           rst_b,
	// Host access port
	input  wire rfac_req_t                      req,
	output rfac_rsp_t                           rsp_ff,
	// Software reset request, one-cycle pulse
	input  wire logic                           sw_rst,
	// Hardware conditions, events and busy levels per bit
	input  wire logic [REG_CNT*RFAC_DATA_W-1:0] hw_in,
	// Stored field values toward the device logic
	output logic      [REG_CNT*RFAC_DATA_W-1:0] field_ff
);

	localparam int BIT_CNT = REG_CNT * RFAC_DATA_W;

	// Refused at elaboration so a bad bank never reaches simulation or synthesis
	if (REG_CNT < 1 || REG_CNT > (1 << RFAC_ADDR_W))
	begin : g_bad_cnt
		$error("rfac_bank: REG_CNT out of range for the address width");
	end

	// Register index match, shared by the write and read paths
	function automatic logic addr_hit(input logic [RFAC_ADDR_W-1:0] addr, input int idx);
		addr_hit = (addr == RFAC_ADDR_W'(idx));
	endfunction : addr_hit

	// Attribute code of one cell, taken from the packed map
	function automatic logic [RFAC_ATTR_W-1:0] code_of(input int idx);
		code_of = ATTR_MAP[idx*RFAC_ATTR_W +: RFAC_ATTR_W];
	endfunction : code_of

	logic                   wr_take;
	logic                   rd_take;
	logic                   mapped;
	logic [REG_CNT-1:0]     wr_sel;
	logic [REG_CNT-1:0]     rd_sel;
	logic [BIT_CNT-1:0]     read_view;
	logic [RFAC_DATA_W-1:0] nxt_rdata;
	rfac_rsp_t              nxt_rsp;

	// A simultaneous read is dropped so a read side effect never pairs with a write
	assign wr_take = req.wr;
	assign rd_take = req.rd & ~req.wr;
	// One extra bit so a full bank of every address still counts as mapped
	assign mapped  = ({1'b0, req.addr} < (RFAC_ADDR_W+1)'(REG_CNT));

	always_comb
	begin
		for (int r = 0; r < REG_CNT; r++)
		begin
			wr_sel[r] = wr_take & addr_hit(req.addr, r);
			rd_sel[r] = rd_take & addr_hit(req.addr, r);
		end
	end

	genvar g;
	generate
		for (g = 0; g < BIT_CNT; g++)
		begin : g_cell
			localparam int REG_IDX = g / RFAC_DATA_W;
			localparam logic [RFAC_ATTR_W-1:0] CODE = code_of(g);
			if (CODE > RFAC_ATTR_LAST)
			begin : g_bad
				$error("rfac_bank: illegal attribute code");
			end
			rfac_bit_cell #(
				.ATTR      (rfac_attr_t'(CODE)),
				.RESET_BIT (RESET_MAP[g]),
				.IMMUNE    (IMMUNE_MAP[g])
			) u_cell (
				.clk      (clk),
				.rst_b    (rst_b),
				.wr_hit   (wr_sel[REG_IDX]),
				.wr_bit   (req.wdata[g % RFAC_DATA_W]),
				.rd_hit   (rd_sel[REG_IDX]),
				.sw_rst   (sw_rst),
				.hw_in    (hw_in[g]),
				.value_ff (field_ff[g]),
				.read_bit (read_view[g])
			);
		end
	endgenerate

	// Read data is the value before this cycle's clear-on-read takes effect
	always_comb
	begin
		nxt_rdata = RFAC_UNREAD;
		for (int r = 0; r < REG_CNT; r++)
		begin
			if (rd_sel[r])
				nxt_rdata = read_view[r*RFAC_DATA_W +: RFAC_DATA_W];
		end
	end

	always_comb
	begin
		nxt_rsp.valid = wr_take | rd_take;
		nxt_rsp.err   = (wr_take | rd_take) & ~mapped;
		nxt_rsp.rdata = nxt_rdata;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			rsp_ff <= RFAC_RSP_RST;
		else
			rsp_ff <= nxt_rsp;
	end

endmodule : rfac_bank

// ---- rtl/rfac_bit_cell.sv ----
// One register bit cell carrying a single access attribute
`timescale 1ns/1ps
module rfac_bit_cell
	import rfac_pkg::*;
#(
	parameter rfac_attr_t ATTR      = RFAC_READ_WRITE,
	parameter logic       RESET_BIT = 1'b0,
	parameter logic       IMMUNE    = 1'b0
)
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// Software side
	input  wire logic wr_hit,
	input  wire logic wr_bit,
	input  wire logic rd_hit,
	input  wire logic sw_rst,
	// Hardware side
	input  wire logic hw_in,
	// Stored value and read view
	output logic      value_ff,
	output logic      read_bit
);

	logic nxt_value;

	always_comb
	begin
		nxt_value = value_ff;
		unique case (ATTR)
			RFAC_RESERVED:
				nxt_value = RESET_BIT;
			RFAC_READ_ONLY:
				nxt_value = hw_in;
			RFAC_WRITE_ONLY, RFAC_READ_WRITE:
				nxt_value = wr_hit ? wr_bit : value_ff;
			RFAC_WRITE_ONE_CLEAR:
				nxt_value = (value_ff & ~(wr_hit & wr_bit)) | hw_in;
			RFAC_WRITE_ANY_CLEAR:
				nxt_value = (value_ff & ~wr_hit) | hw_in;
			RFAC_CLEAR_ON_READ, RFAC_LATCH_HIGH:
				nxt_value = (value_ff & ~rd_hit) | hw_in;
			RFAC_RO_LATCHED_HIGH:
				nxt_value = (value_ff & ~rd_hit) | hw_in;
			RFAC_LATCH_LOW:
				// Low condition wins over the release
				nxt_value = (value_ff | rd_hit) & hw_in;
			RFAC_SELF_CLEARING:
				// Holds while hw_in reports the action still busy
				nxt_value = (wr_hit & wr_bit) | (value_ff & hw_in);
			RFAC_SELF_SETTING:
				// Holds low while hw_in reports the action still busy
				nxt_value = ~((wr_hit & ~wr_bit) | (~value_ff & hw_in));
			default:
				nxt_value = value_ff;
		endcase
		if (sw_rst && !IMMUNE)
			nxt_value = RESET_BIT;
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
			value_ff <= RESET_BIT;
		else
			value_ff <= nxt_value;
	end

	// Write-only and reserved bits read back as zero
	always_comb
	begin
		unique case (ATTR)
			RFAC_RESERVED, RFAC_WRITE_ONLY:
				read_bit = 1'b0;
			default:
				read_bit = value_ff;
		endcase
	end

endmodule : rfac_bit_cell

// ---- test/rfac_bank_assertions.sv ----
// Port checks for the field access bank
`timescale 1ns/1ps
module rfac_chk
	import rfac_pkg::*;
#(
	parameter int REG_CNT = 4
)
(
	// Watched ports
	input wire logic                           clk,
	input wire logic                           rst_b,
	input wire rfac_req_t                      req,
	input wire rfac_rsp_t                      rsp_ff,
	input wire logic                           sw_rst,
	input wire logic [REG_CNT*RFAC_DATA_W-1:0] hw_in,
	input wire logic [REG_CNT*RFAC_DATA_W-1:0] field_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire logic rd2 = req.rd && !req.wr && req.addr == 4'h2;
	wire logic rd3 = req.rd && !req.wr && req.addr == 4'h3;
	AST_VALID: assert property ((req.rd || req.wr) |=> rsp_ff.valid)
		else $error("no answer");
	AST_RDATA0: assert property ((!req.rd || req.wr) |=> rsp_ff.rdata == '0)
		else $error("data without read");
	AST_RC: assert property (rd2 && !hw_in[32] && !sw_rst |=>
		!field_ff[32] && rsp_ff.rdata[0] == $past(field_ff[32])) else $error("read clear");
	AST_LATCH: assert property (field_ff[48] && !rd3 && !sw_rst |=> field_ff[48])
		else $error("latch lost");
	AST_AFTER: assert property (rd3 && !sw_rst |=> field_ff[49] == $past(hw_in[49]))
		else $error("latch release");
	AST_SETW: assert property (hw_in[16] && !sw_rst |=> field_ff[16])
		else $error("set lost");
	AST_W1C: assert property (req.wr && req.addr == 4'h1 && req.wdata[0] && !hw_in[16]
		&& !sw_rst |=> !field_ff[16]) else $error("one write clear");
	AST_IMM: assert property (sw_rst && field_ff[63] && !rd3 |=> field_ff[63])
		else $error("immune cell reset");
	AST_WO: assert property (req.rd && !req.wr && req.addr == 4'h0 |=> !rsp_ff.rdata[2])
		else $error("write-only bit read back");
	cover property (rd3 && field_ff[48]);
	cover property (rd2 && field_ff[32]);
	cover property (sw_rst && field_ff[63]);
	cover property (req.wr && req.addr == 4'hF);
endmodule : rfac_chk

// ---- test/tb_register_field_access_cells.sv ----
// Random and directed test of the field access bank
`timescale 1ns/1ps
module tb_register_field_access_cells;
	import rfac_pkg::*;
	localparam logic [255:0] AMAP = {{16{4'hB}}, {16{4'h6}}, {16{4'h4}}, {4{4'h3}}, 48'hBA9876543210};
	localparam logic [63:0] RMAP = 64'h0000_0000_0000_0480;
	localparam logic [63:0] IMAP = 64'h8000_0000_0000_2000;
	logic      clk = 0, rst_b = 0, sw = 0, w, r;
	rfac_req_t rq = '0;
	rfac_rsp_t rsp, er;
	logic      [63:0] hw = 64'h80, fld, m, nm;
	logic      [3:0] a;
	int        seed = 34, bad_count = 0, n_checks = 0, cyc = 0;
	rfac_bank #(.ATTR_MAP(AMAP), .RESET_MAP(RMAP), .IMMUNE_MAP(IMAP)) uut (.clk(clk),
		.rst_b(rst_b), .req(rq), .rsp_ff(rsp), .sw_rst(sw), .hw_in(hw), .field_ff(fld));
	initial forever #20 clk = ~clk;
	function automatic logic nxt(input logic [3:0] a, input logic v, h, w, b, r, z);
		case (a)
			4'h0: return z;
			4'h1: return h;
			4'h2, 4'h3: return w ? b : v;
			4'h4: return (v & ~(w & b)) | h;
			4'h5: return (v & ~w) | h;
			4'h7: return (v | r) & h;
			4'h9: return (w & b) | (v & h);
			4'hA: return ~((w & ~b) | (~v & h));
			default: return (v & ~r) | h;
		endcase
	endfunction : nxt
	function automatic logic [15:0] no_rsv(input logic [3:0] ad, input logic [15:0] d);
		for (int b = 0; b < 16; b++)
			if (ad < 4'h4 && AMAP[4*(16*ad+b)+:4] == 4'h0)
				d[b] = 1'b0;
		return d;
	endfunction : no_rsv
	// Model reads inputs at the edge; they only move 1 ns later
	always @(posedge clk or negedge rst_b)
		if (!rst_b)
		begin
			m = RMAP;
			er = '0;
		end
		else
		begin
			er = '0;
			er.valid = rq.rd | rq.wr;
			er.err = er.valid & (rq.addr > 4'h3);
			for (int g = 0; g < 64; g++)
			begin
				a = AMAP[4*g+:4];
				w = rq.wr && rq.addr == g / 16;
				r = rq.rd && !rq.wr && rq.addr == g / 16;
				if (r && a != 4'h0 && a != 4'h2)
					er.rdata[g%16] = m[g];
				nm[g] = (sw && !IMAP[g]) ? RMAP[g] : nxt(a, m[g], hw[g], w, rq.wdata[g%16], r, RMAP[g]);
			end
			m = nm;
		end
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	task automatic chk_fld(input logic [63:0] e);
		n_checks++;
		if (fld !== e)
		begin
			bad_count++;
			$display("unexpected field_ff exp %h got %h", e, fld);
		end
	endtask : chk_fld
	task automatic chk_rsp(input rfac_rsp_t e);
		n_checks++;
		if (rsp !== e)
		begin
			bad_count++;
			$display("unexpected rsp_ff exp %h got %h", e, rsp);
		end
	endtask : chk_rsp
	always @(negedge clk)
		if (rst_b)
		begin
			chk_fld(m);
			chk_rsp(er);
		end
	always @(posedge clk)
		if (++cyc == 6000)
		begin
			bad_count++;
			close_out();
		end
	task automatic acc(input logic rd, wr, input logic [3:0] ad, input logic [15:0] d,
		input logic [63:0] h, input logic s);
		@(posedge clk);
		#1;
		rq = '{rd, wr, ad, no_rsv(ad, d)};
		hw = h;
		sw = s;
	endtask : acc
	initial
	begin
		repeat (20) @(posedge clk);
		#1 rst_b = 1;
		acc(0, 1, 4'h0, 16'hFFFF, 64'h80, 0);
		acc(0, 0, 4'h0, 16'h0000, '1, 0);
		acc(0, 0, 4'h0, 16'h0000, 64'h80, 1);
		acc(1, 0, 4'h2, 16'h0000, 64'h80, 0);
		acc(1, 0, 4'h2, 16'h0000, 64'h80, 0);
		acc(1, 1, 4'h3, 16'hFFFF, 64'h80, 0);
		acc(1, 0, 4'h3, 16'h0000, 64'h80, 0);
		acc(0, 1, 4'h1, 16'hFFFF, 64'h80, 0);
		acc(0, 1, 4'hF, 16'hFFFF, 64'h80, 0);
		$display("directed test done");
		repeat (3000)
			acc({$random(seed)} % 4 == 0, {$random(seed)} % 4 == 0, 4'({$random(seed)} % 5),
				16'($random(seed)), {$random(seed), $random(seed)}, {$random(seed)} % 32 == 0);
		// Idle and let the last request be answered and compared
		acc(0, 0, 4'h0, 16'h0000, 64'h80, 0);
		repeat (2) @(posedge clk);
		$display("random test done");
		close_out();
	end
endmodule : tb_register_field_access_cells
bind rfac_bank rfac_chk #(.REG_CNT(REG_CNT)) u_chk (.clk(clk), .rst_b(rst_b), .req(req),
	.rsp_ff(rsp_ff), .sw_rst(sw_rst), .hw_in(hw_in), .field_ff(field_ff));
